// >>> rtl/schfa_core.sv
// Homing control, state store and saturating fixed-point ALU of the codec.
// Assumes the decoder core drains parameters and returns 160 samples per frame.
`timescale 1ns/10ps
`default_nettype none
module schfa_core (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Received parameter frame in
  input  wire logic        par_valid,
  output logic             par_ready,
  input  wire logic [15:0] par_data,
  input  wire logic        par_bad,
  // Masked parameters to the decoder core
  output logic             dpar_valid_q,
  output logic [15:0]      dpar_data_q,
  output logic             home_early_q,
  // Decoded speech from the core and out
  input  wire logic        dsmp_valid,
  input  wire logic [15:0] dsmp_data,
  output logic             spk_valid_q,
  output logic [15:0]      spk_data_q,
  // Encoder speech input, masked
  input  wire logic        esmp_valid,
  input  wire logic [15:0] esmp_data,
  output logic             emsk_valid_q,
  output logic [15:0]      emsk_data_q,
  // Encoder homing request from the encoder side
  input  wire logic        enc_home_req,
  // State store port
  input  wire logic        st_we,
  input  wire logic [8:0]  st_addr,
  input  wire logic [31:0] st_wdata,
  output logic [31:0]      st_rdata_q,
  output logic             home_busy,
  // Arithmetic unit
  input  wire logic        alu_valid,
  input  wire logic [3:0]  alu_op,
  input  wire logic [31:0] alu_a,
  input  wire logic [31:0] alu_b,
  output logic             alu_done_q,
  output logic [31:0]      alu_res_q
);
  localparam int NPW = $clog2(schfa_pkg::N_PAR);
  localparam int NSW = $clog2(schfa_pkg::N_SMP);

  function automatic logic [15:0] sat16(input logic signed [16:0] v);
    if (v > 17'sh07FFF) sat16 = schfa_pkg::MAX16;
    else if (v < -17'sh08000) sat16 = schfa_pkg::MIN16;
    else sat16 = v[15:0];
  endfunction

  function automatic logic [31:0] sat32(input logic signed [32:0] v);
    if (v[32] != v[31]) sat32 = v[32] ? schfa_pkg::MIN32 : schfa_pkg::MAX32;
    else sat32 = v[31:0];
  endfunction

  // Negative counts flip the direction; counts past the width fill fully
  function automatic logic [31:0] shift32(input logic [31:0] x,
                                          input logic [15:0] n,
                                          input logic left);
    logic [16:0] mag;
    logic        go_left;
    mag = n[15] ? 17'(-$signed({n[15], n})) : {1'b0, n};
    go_left = left ^ n[15];
    if (go_left) shift32 = x << mag;
    else shift32 = 32'($signed(x) >>> mag);
  endfunction

  // Restoring division, 15 quotient bits
  function automatic logic [15:0] fdiv(input logic [15:0] num, input logic [15:0] den);
    logic [31:0] r;
    logic [15:0] q;
    r = {16'h0000, num};
    q = 16'h0000;
    for (int i = 0; i < schfa_pkg::FRAC_SH; i++) begin
      q = {q[14:0], 1'b0};
      r = {r[30:0], 1'b0};
      if (r >= {16'h0000, den}) begin
        r = r - {16'h0000, den};
        q = q + 16'h0001;
      end
    end
    fdiv = (num == den) ? schfa_pkg::MAX16 : q;
  endfunction

  function automatic logic [15:0] home_word(input logic [NPW-1:0] i);
    logic [4:0] k;
    if (i < NPW'(schfa_pkg::N_LAR)) begin
      case (i[2:0])
        3'h0: home_word = 16'h0009;
        3'h1: home_word = 16'h0017;
        3'h2: home_word = 16'h000F;
        3'h3: home_word = 16'h0008;
        3'h4: home_word = 16'h0007;
        3'h5: home_word = 16'h0003;
        3'h6: home_word = 16'h0003;
        default: home_word = 16'h0002;
      endcase
    end else begin
      k = 5'((i - NPW'(schfa_pkg::N_LAR)) % NPW'(schfa_pkg::N_SUB_PAR));
      if (i == NPW'(schfa_pkg::ODD_IDX)) home_word = schfa_pkg::ODD_PULSE;
      else if (k == 5'h00) home_word = schfa_pkg::HOME_LAG;
      else if (k < 5'h04) home_word = 16'h0000;
      else home_word = schfa_pkg::HOME_PULSE;
    end
  endfunction

  // Valid low bits of each coded parameter
  function automatic logic [15:0] par_mask(input logic [NPW-1:0] i);
    logic [4:0] k;
    logic [3:0] w;
    k = 5'((i - NPW'(schfa_pkg::N_LAR)) % NPW'(schfa_pkg::N_SUB_PAR));
    if (i < NPW'(schfa_pkg::N_LAR)) w = 4'(6 - (i[2:0] >> 1));
    else if (k == 5'h00) w = 4'h7;
    else if (k < 5'h03) w = 4'h2;
    else if (k == 5'h03) w = 4'h6;
    else w = 4'h3;
    par_mask = 16'((32'h1 << w) - 32'h1);
  endfunction

  // Arithmetic unit
  logic signed [31:0] prod;
  logic [15:0]        a16;
  logic [15:0]        b16;
  logic               both_min;
  logic [31:0]        alu_d;
  logic [15:0]        r16;
  assign a16 = alu_a[15:0];
  assign b16 = alu_b[15:0];
  assign prod = 32'($signed(a16)) * 32'($signed(b16));
  assign both_min = (a16 == schfa_pkg::MIN16) && (b16 == schfa_pkg::MIN16);

  always_comb begin
    r16 = 16'h0000;
    alu_d = 32'h00000000;
    case (schfa_pkg::schfa_op_t'(alu_op))
      schfa_pkg::OP_ADD: r16 = sat16(17'($signed(a16)) + 17'($signed(b16)));
      schfa_pkg::OP_SUB: r16 = sat16(17'($signed(a16)) - 17'($signed(b16)));
      schfa_pkg::OP_MULT:
        r16 = both_min ? schfa_pkg::MAX16 : 16'(prod >>> schfa_pkg::FRAC_SH);
      schfa_pkg::OP_MULTR:
        r16 = both_min ? schfa_pkg::MAX16
                       : 16'((prod + $signed(schfa_pkg::RND_HALF)) >>> schfa_pkg::FRAC_SH);
      schfa_pkg::OP_ABS:
        r16 = (a16 == schfa_pkg::MIN16) ? schfa_pkg::MAX16 : (a16[15] ? 16'(-a16) : a16);
      schfa_pkg::OP_DIV: r16 = fdiv(a16, b16);
      schfa_pkg::OP_SHL: r16 = 16'(shift32({{16{a16[15]}}, a16}, b16, 1'b1));
      schfa_pkg::OP_SHR: r16 = 16'(shift32({{16{a16[15]}}, a16}, b16, 1'b0));
      schfa_pkg::OP_EXTRACT: r16 = alu_a[15:0];
      default: r16 = a16; // OP_DEPOSIT
    endcase
    case (schfa_pkg::schfa_op_t'(alu_op))
      schfa_pkg::OP_LMULT: alu_d = 32'(prod <<< 1);
      schfa_pkg::OP_LADD: alu_d = sat32(33'($signed(alu_a)) + 33'($signed(alu_b)));
      schfa_pkg::OP_LSUB: alu_d = sat32(33'($signed(alu_a)) - 33'($signed(alu_b)));
      schfa_pkg::OP_LSHL: alu_d = shift32(alu_a, b16, 1'b1);
      schfa_pkg::OP_LSHR: alu_d = shift32(alu_a, b16, 1'b0);
      default: alu_d = {{16{r16[15]}}, r16};
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      alu_done_q <= 1'b0;
      alu_res_q <= 32'h00000000;
    end else begin
      alu_done_q <= alu_valid;
      alu_res_q <= alu_valid ? alu_d : alu_res_q;
    end
  end

  // Homing control
  schfa_pkg::schfa_state_t st_q, st_d;
  logic [8:0]     swp_q, swp_d, lo_q, lo_d, hi_q, hi_d;
  logic [NPW-1:0] pidx_q, pidx_d;
  logic [NSW-1:0] sidx_q, sidx_d;
  logic           home_q, home_d, hstart_q, hstart_d, match_q, match_d;
  logic           subst_q, subst_d, pend_q, pend_d, epend_q, epend_d, early_d;
  logic           par_take, smp_take, wmatch;

  assign home_busy = (st_q == schfa_pkg::S_SWEEP);
  assign par_ready = !home_busy && !pend_q;
  assign par_take = par_valid && par_ready;
  assign smp_take = dsmp_valid;
  assign wmatch = ((par_data & par_mask(pidx_q)) == home_word(pidx_q));

  always_comb begin
    st_d = st_q;
    swp_d = swp_q;
    lo_d = lo_q;
    hi_d = hi_q;
    pidx_d = pidx_q;
    sidx_d = sidx_q;
    home_d = home_q;
    hstart_d = hstart_q;
    match_d = match_q;
    subst_d = subst_q;
    pend_d = pend_q;
    epend_d = epend_q || enc_home_req;
    early_d = home_early_q;
    if (par_take) begin
      if (pidx_q == '0) begin
        hstart_d = home_q;
        match_d = wmatch;
        early_d = 1'b0;
      end else begin
        match_d = match_q && wmatch;
      end
      // Only LARs and the first subframe are needed when starting from home
      if (pidx_q == NPW'(schfa_pkg::N_LAR + schfa_pkg::N_SUB_PAR - 1))
        early_d = (pidx_q == '0 ? home_q : hstart_q) && match_d;
      if (pidx_q == NPW'(schfa_pkg::N_PAR - 1)) begin
        pidx_d = '0;
        pend_d = match_d && !par_bad;
        subst_d = match_d && !par_bad && hstart_q;
        home_d = 1'b0;
      end else begin
        pidx_d = pidx_q + 1'b1;
      end
    end
    if (smp_take) begin
      if (sidx_q == NSW'(schfa_pkg::N_SMP - 1)) begin
        sidx_d = '0;
        subst_d = 1'b0;
      end else begin
        sidx_d = sidx_q + 1'b1;
      end
    end
    case (st_q)
      schfa_pkg::S_IDLE: begin
        if (pend_q && smp_take && sidx_q == NSW'(schfa_pkg::N_SMP - 1)) begin
          st_d = schfa_pkg::S_SWEEP;
          lo_d = schfa_pkg::A_DEC_LAG;
          hi_d = schfa_pkg::A_DEC_END;
          swp_d = schfa_pkg::A_DEC_LAG;
          pend_d = 1'b0;
        // Encoder sweep waits: the decoder trigger is only seen while idle
        end else if (epend_q && !pend_q) begin
          st_d = schfa_pkg::S_SWEEP;
          lo_d = schfa_pkg::A_OFS_NR;
          hi_d = schfa_pkg::A_ENC_END;
          swp_d = schfa_pkg::A_OFS_NR;
          epend_d = enc_home_req;
        end
      end
      schfa_pkg::S_SWEEP: begin
        swp_d = swp_q + 9'h001;
        if (swp_q == hi_q) begin
          st_d = schfa_pkg::S_IDLE;
          if (hi_q == schfa_pkg::A_DEC_END) home_d = 1'b1;
        end
      end
      default: st_d = schfa_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      // Reset runs the same sweep as inband homing over both halves
      st_q <= schfa_pkg::S_SWEEP;
      swp_q <= schfa_pkg::A_OFS_NR;
      lo_q <= schfa_pkg::A_OFS_NR;
      hi_q <= schfa_pkg::A_DEC_END;
      pidx_q <= '0;
      sidx_q <= '0;
      home_q <= 1'b0;
      hstart_q <= 1'b0;
      match_q <= 1'b0;
      subst_q <= 1'b0;
      pend_q <= 1'b0;
      epend_q <= 1'b0;
      home_early_q <= 1'b0;
    end else begin
      st_q <= st_d;
      swp_q <= swp_d;
      lo_q <= lo_d;
      hi_q <= hi_d;
      pidx_q <= pidx_d;
      sidx_q <= sidx_d;
      home_q <= home_d;
      hstart_q <= hstart_d;
      match_q <= match_d;
      subst_q <= subst_d;
      pend_q <= pend_d;
      epend_q <= epend_d;
      home_early_q <= early_d;
    end
  end

  // State store; the sweep owns the write port while busy
  logic [31:0] mem [schfa_pkg::ST_WORDS];
  logic [31:0] home_val;
  assign home_val = (swp_q == schfa_pkg::A_DEC_LAG) ? {16'h0000, schfa_pkg::HOME_LAG}
                                                    : 32'h00000000;
  always_ff @(posedge ref_clk) begin
    if (home_busy) mem[swp_q] <= home_val;
    else if (st_we) mem[st_addr] <= st_wdata;
    st_rdata_q <= mem[st_addr];
  end

  // Data paths with bit masking and output substitution
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dpar_valid_q <= 1'b0;
      dpar_data_q <= 16'h0000;
      spk_valid_q <= 1'b0;
      spk_data_q <= 16'h0000;
      emsk_valid_q <= 1'b0;
      emsk_data_q <= 16'h0000;
    end else begin
      dpar_valid_q <= par_take;
      dpar_data_q <= par_data & par_mask(pidx_q);
      spk_valid_q <= smp_take;
      spk_data_q <= subst_q ? schfa_pkg::ENC_HOME : (dsmp_data & schfa_pkg::SMP_MASK);
      emsk_valid_q <= esmp_valid;
      emsk_data_q <= esmp_data & schfa_pkg::SMP_MASK;
    end
  end

  sequence s_sweep_start;
    $rose(home_busy);
  endsequence
  sequence s_sweep_end;
    !home_busy;
  endsequence

  a_abs_min: assert property (@(posedge ref_clk) disable iff (!rst_n)
    alu_valid && alu_op == 4'h4 && alu_a[15:0] == 16'h8000 |=> alu_res_q == 32'h00007FFF)
    else $error("abs of minimum not 32767");
  a_mult_min: assert property (@(posedge ref_clk) disable iff (!rst_n)
    alu_valid && alu_op == 4'h2 && both_min |=> alu_res_q[15:0] == 16'h7FFF)
    else $error("mult min case wrong");
  a_multr_min: assert property (@(posedge ref_clk) disable iff (!rst_n)
    alu_valid && alu_op == 4'h3 && both_min |=> alu_res_q[15:0] == 16'h7FFF)
    else $error("mult_r min case wrong");
  a_div_equal: assert property (@(posedge ref_clk) disable iff (!rst_n)
    alu_valid && alu_op == 4'h5 && a16 == b16 |=> alu_res_q == 32'h00007FFF)
    else $error("div of equal operands wrong");
  a_add_posov: assert property (@(posedge ref_clk) disable iff (!rst_n)
    alu_valid && alu_op == 4'h0 && !a16[15] && !b16[15] && prod == prod
      && ({1'b0, a16} + {1'b0, b16}) > 17'h07FFF |=> alu_res_q == 32'h00007FFF)
    else $error("add positive overflow wrong");
  a_ladd_negov: assert property (@(posedge ref_clk) disable iff (!rst_n)
    alu_valid && alu_op == 4'h7 && alu_a[31] && alu_b[31]
      && $signed(alu_a) + $signed(alu_b) < -33'sh080000000 |=> alu_res_q == 32'h80000000)
    else $error("L_add negative overflow wrong");
  a_subst_out: assert property (@(posedge ref_clk) disable iff (!rst_n)
    smp_take && subst_q |=> spk_valid_q && spk_data_q == 16'h0008)
    else $error("homing frame not substituted");
  a_sweep_done: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_sweep_start |-> ##[1:300] s_sweep_end)
    else $error("homing sweep too long");
  a_ready_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    par_take && pidx_q == NPW'(schfa_pkg::N_PAR - 1) && match_d && !par_bad |=> !par_ready)
    else $error("parameters taken while homing pends");
  a_lag_home: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(home_busy) && hi_q == schfa_pkg::A_DEC_END |-> mem[schfa_pkg::A_DEC_LAG] == 32'h00000028)
    else $error("home lag not 40");
endmodule
`default_nettype wire

// >>> rtl/schfa_pkg.sv
// Constants for the speech codec homing and fixed-point arithmetic block.
// Assumes one processing clock and a frame of 76 coded parameters.
package schfa_pkg;
  // Arithmetic limits
  localparam logic [15:0] MAX16     = 16'h7FFF;
  localparam logic [15:0] MIN16     = 16'h8000;
  localparam logic [31:0] MAX32     = 32'h7FFFFFFF;
  localparam logic [31:0] MIN32     = 32'h80000000;
  localparam logic [31:0] RND_HALF  = 32'h00004000;
  localparam int          FRAC_SH   = 15;
  // Frame layout
  localparam int          N_PAR     = 76;
  localparam int          N_LAR     = 8;
  localparam int          N_SUB_PAR = 17;
  localparam int          N_SMP     = 160;
  localparam logic [15:0] SMP_MASK  = 16'hFFF8;
  localparam logic [15:0] ENC_HOME  = 16'h0008;
  localparam logic [15:0] HOME_LAG  = 16'h0028;
  localparam logic [15:0] HOME_PULSE = 16'h0004;
  localparam logic [15:0] ODD_PULSE = 16'h0003;
  localparam int          ODD_IDX   = 8 + 3 * 17 + 4 + 4;
  // State store map, word addresses
  localparam logic [8:0] A_OFS_NR   = 9'h000;
  localparam logic [8:0] A_OFS_ACC  = 9'h001;
  localparam logic [8:0] A_TILT     = 9'h002;
  localparam logic [8:0] A_ENC_LAR  = 9'h003;
  localparam logic [8:0] A_ENC_U    = 9'h00B;
  localparam logic [8:0] A_ENC_PITCH = 9'h013;
  localparam logic [8:0] A_VAD_DTX  = 9'h08B;
  localparam logic [8:0] A_ENC_END  = 9'h092;
  localparam logic [8:0] A_DEC_LAG  = 9'h093;
  localparam logic [8:0] A_DEC_DRP  = 9'h094;
  localparam logic [8:0] A_DEC_LAR  = 9'h10C;
  localparam logic [8:0] A_DEC_V    = 9'h114;
  localparam logic [8:0] A_DEEMPH   = 9'h11D;
  localparam logic [8:0] A_EC_CN    = 9'h11E;
  localparam logic [8:0] A_DEC_END  = 9'h125;
  localparam int         ST_WORDS   = 294;
  // Arithmetic operations
  typedef enum logic [3:0] {
    OP_ADD = 4'h0, OP_SUB = 4'h1, OP_MULT = 4'h2, OP_MULTR = 4'h3,
    OP_ABS = 4'h4, OP_DIV = 4'h5, OP_LMULT = 4'h6, OP_LADD = 4'h7,
    OP_LSUB = 4'h8, OP_SHL = 4'h9, OP_SHR = 4'hA, OP_LSHL = 4'hB,
    OP_LSHR = 4'hC, OP_DEPOSIT = 4'hD, OP_EXTRACT = 4'hE
  } schfa_op_t;
  typedef enum logic [1:0] {
    S_IDLE  = 2'b01,
    S_SWEEP = 2'b10
  } schfa_state_t;
endpackage

// >>> dv/schfa_far_end.sv
// Far-end model: transmission path sending coded frames, decoder core returning speech.
// Assumes calls from the falling edge and a fresh seed from the bench for each task.
`timescale 1ns/10ps
`default_nettype none
module schfa_far_end (
  // Clock
  input  wire logic        ref_clk,
  // Coded frame path
  input  wire logic        par_ready,
  output logic             par_valid,
  output logic [15:0]      par_data,
  output logic             par_bad,
  // Decoded speech path
  output logic             dsmp_valid,
  output logic [15:0]      dsmp_data
);
  logic [31:0] s;
  int          n_stall = 0;

  initial begin
    par_valid = 1'b0;
    par_data = 16'h0000;
    par_bad = 1'b0;
    dsmp_valid = 1'b0;
    dsmp_data = 16'h0000;
  end

  function automatic logic [31:0] step(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction

  function automatic logic [15:0] home_word(input int i);
    logic [15:0] lar [8] = '{16'h0009, 16'h0017, 16'h000F, 16'h0008,
                             16'h0007, 16'h0003, 16'h0003, 16'h0002};
    int          j;
    j = (i - 8) % 17;
    if (i < 8) return lar[i];
    if (j == 0) return 16'h0028;
    if (j < 4) return 16'h0000;
    return i == schfa_pkg::ODD_IDX ? 16'h0003 : 16'h0004;
  endfunction

  // A word stands until an edge sees par_ready high; idle data never repeats the last word
  task automatic send_frame(input bit hom, input bit bad, input bit slow, input logic [31:0] sd);
    int          w;
    logic [15:0] v;
    s = sd;
    for (int i = 0; i < 76; i++) begin
      s = step(s);
      v = hom ? home_word(i) : s[15:0];
      if (!hom && i == 0 && v[5:0] == 6'h09) v[0] = ~v[0];
      v = v | {s[31:23], 7'h00};
      if (slow && s[3]) begin
        par_valid = 1'b0;
        par_data = ~par_data;
        @(negedge ref_clk);
      end
      par_valid = 1'b1;
      par_data = v;
      par_bad = bad && i == 75;
      w = 0;
      while (par_ready !== 1'b1 && w < 1000) begin
        @(negedge ref_clk);
        w++;
      end
      if (par_ready !== 1'b1) n_stall++;
      @(negedge ref_clk);
    end
    par_valid = 1'b0;
    par_bad = 1'b0;
    par_data = ~par_data;
  endtask

  // The core has no back-pressure on speech, so samples may come back to back
  task automatic send_speech(input bit slow, input logic [31:0] sd);
    s = sd;
    for (int k = 0; k < 160; k++) begin
      s = step(s);
      if (slow && s[7]) begin
        dsmp_valid = 1'b0;
        dsmp_data = ~dsmp_data;
        @(negedge ref_clk);
      end
      dsmp_valid = 1'b1;
      dsmp_data = s[15:0];
      @(negedge ref_clk);
    end
    dsmp_valid = 1'b0;
    dsmp_data = ~dsmp_data;
  endtask
endmodule
`default_nettype wire

// >>> dv/speech_codec_homing_fixed_arith_bench.sv
// Self-checking bench: frames, speech, state store and a reference ALU model.
// Assumes schfa_far_end as the far side and the constants of schfa_pkg.
`timescale 1ns/10ps
`default_nettype none
module speech_codec_homing_fixed_arith_bench;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        par_valid, par_ready, par_bad, dpar_valid_q, home_early_q;
  logic        dsmp_valid, spk_valid_q, emsk_valid_q, home_busy, alu_done_q;
  logic        esmp_valid = 1'b0;
  logic        enc_home_req = 1'b0;
  logic        st_we = 1'b0;
  logic        alu_valid = 1'b0;
  logic [15:0] par_data, dpar_data_q, dsmp_data, spk_data_q, emsk_data_q;
  logic [15:0] esmp_data = 16'h0000;
  logic [8:0]  st_addr = 9'h000;
  logic [31:0] st_wdata = 32'h00000000;
  logic [31:0] st_rdata_q, alu_res_q;
  logic [3:0]  alu_op = 4'h0;
  logic [31:0] alu_a = 32'h00000000;
  logic [31:0] alu_b = 32'h00000000;
  int          n_fail = 0;
  int          check_count = 0;
  int          widx = 0;
  bit          sub_exp = 1'b0;
  bit          home = 1'b1;
  logic [31:0] rs = 32'h3BD60154;
  logic [15:0] exp_spk [$];
  logic [15:0] exp_par [$];
  logic [6:0]  fh = 7'b1101110;
  logic [6:0]  fb = 7'b0001000;
  // First 11 in the encoder range, the rest decoder
  logic [8:0]  zmap [20] = '{9'h000, 9'h001, 9'h002, 9'h003, 9'h00A, 9'h00B, 9'h012, 9'h013,
                             9'h08A, 9'h08B, 9'h092, 9'h094, 9'h10B, 9'h10C, 9'h113, 9'h114,
                             9'h11C, 9'h11D, 9'h11E, 9'h125};
  logic [3:0]  eop [15] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9,
                            4'hA, 4'hB, 4'hC, 4'hD};
  logic [31:0] ea [15] = '{32'h7FFF, 32'h8000, 32'h8000, 32'h8000, 32'h1, 32'h8000, 32'h1234,
                           32'h7FFF, 32'h7FFFFFFF, 32'h80000000, 32'hF001, 32'h8001,
                           32'h10001, 32'h80000000, 32'h18000};
  logic [31:0] eb [15] = '{32'h1, 32'h1, 32'h8000, 32'h8000, 32'h4000, 32'h0, 32'h1234,
                           32'h7FFF, 32'h1, 32'h1, 32'hFFFD, 32'hFFFC, 32'h4, 32'h1F, 32'h0};

  schfa_core uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .par_valid(par_valid), .par_ready(par_ready),
    .par_data(par_data), .par_bad(par_bad), .dpar_valid_q(dpar_valid_q),
    .dpar_data_q(dpar_data_q), .home_early_q(home_early_q), .dsmp_valid(dsmp_valid),
    .dsmp_data(dsmp_data), .spk_valid_q(spk_valid_q), .spk_data_q(spk_data_q),
    .esmp_valid(esmp_valid), .esmp_data(esmp_data), .emsk_valid_q(emsk_valid_q),
    .emsk_data_q(emsk_data_q), .enc_home_req(enc_home_req), .st_we(st_we),
    .st_addr(st_addr), .st_wdata(st_wdata), .st_rdata_q(st_rdata_q), .home_busy(home_busy),
    .alu_valid(alu_valid), .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b),
    .alu_done_q(alu_done_q), .alu_res_q(alu_res_q)
  );
  schfa_far_end far (
    .ref_clk(ref_clk), .par_ready(par_ready), .par_valid(par_valid), .par_data(par_data),
    .par_bad(par_bad), .dsmp_valid(dsmp_valid), .dsmp_data(dsmp_data)
  );

  always #2 ref_clk = ~ref_clk;

  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  function automatic logic [15:0] vmask(input int i);
    int lw [8] = '{6, 6, 5, 5, 4, 4, 3, 3};
    int j;
    j = (i - 8) % 17;
    if (i < 8) return 16'hFFFF >> (16 - lw[i]);
    return j == 0 ? 16'h007F : j < 3 ? 16'h0003 : j == 3 ? 16'h003F : 16'h0007;
  endfunction

  function automatic logic [31:0] alu_ref(input logic [3:0] op, input logic [31:0] a,
                                          input logic [31:0] b);
    longint x, y, v, r;
    int     n;
    x = longint'($signed(a[15:0]));
    y = longint'($signed(b[15:0]));
    n = int'($signed(b[15:0]));
    v = op inside {4'h9, 4'hA} ? x : longint'($signed(a));
    case (op)
      4'h0: r = x + y;
      4'h1: r = x - y;
      4'h2: r = (x * y) >>> schfa_pkg::FRAC_SH;
      4'h3: r = (x * y + 64'sh4000) >>> schfa_pkg::FRAC_SH;
      4'h4: r = x < 0 ? -x : x;
      4'h5: r = x == y ? 64'sh7FFF : x * 64'sh8000 / y;
      4'h6: r = (x * y) << 1;
      4'h7: r = v + longint'($signed(b));
      4'h8: r = v - longint'($signed(b));
      4'h9, 4'hB: r = n < 0 ? v >>> -n : v << n;
      4'hA, 4'hC: r = n < 0 ? v << -n : v >>> n;
      default: r = x;
    endcase
    if (op < 4'h6) r = r > 64'sh7FFF ? 64'sh7FFF : (r < -64'sh8000 ? -64'sh8000 : r);
    if (op inside {4'h7, 4'h8})
      r = r > 64'sh7FFFFFFF ? 64'sh7FFFFFFF : (r < -64'sh80000000 ? -64'sh80000000 : r);
    if (op < 4'h6 || op inside {4'h9, 4'hA, 4'hD, 4'hE}) r = longint'($signed(r[15:0]));
    return r[31:0];
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Slack of two cycles covers a sweep that starts one cycle after its trigger
  task automatic wait_idle();
    int w;
    w = 0;
    repeat (2) @(negedge ref_clk);
    while (home_busy !== 1'b0 && w < 600) begin
      @(negedge ref_clk);
      w++;
    end
    if (w == 600) begin
      n_fail++;
      complete_run();
    end
  endtask

  task automatic alu_chk(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b);
    alu_op = op;
    alu_a = a;
    alu_b = b;
    @(negedge ref_clk);
    check({31'h0, alu_done_q}, 32'h1);
    check(alu_res_q, alu_ref(op, a, b));
  endtask

  task automatic dirty();
    st_we = 1'b1;
    for (int i = 0; i < 21; i++) begin
      st_addr = i < 20 ? zmap[i] : 9'h093;
      st_wdata = 32'hA5A50000 | 32'(i);
      @(negedge ref_clk);
    end
    st_we = 1'b0;
  endtask

  task automatic check_map(input bit enc_clr, input bit dec_clr);
    logic [31:0] e;
    for (int i = 0; i < 21; i++) begin
      st_addr = i < 20 ? zmap[i] : 9'h093;
      e = (i < 11 ? enc_clr : dec_clr) ? (i < 20 ? 32'h0 : 32'h28) : 32'hA5A50000 | 32'(i);
      @(negedge ref_clk);
      check(st_rdata_q, e);
    end
  endtask

  always @(posedge ref_clk) begin
    if (spk_valid_q === 1'b1) check(spk_data_q, exp_spk.pop_front());
    if (dpar_valid_q === 1'b1) check(dpar_data_q, exp_par.pop_front());
    if (dsmp_valid)
      exp_spk.push_back(sub_exp ? schfa_pkg::ENC_HOME : dsmp_data & schfa_pkg::SMP_MASK);
    if ((par_valid & par_ready) === 1'b1) begin
      exp_par.push_back(par_data & vmask(widx));
      widx = (widx + 1) % 76;
    end
  end

  initial begin
    #400000;
    n_fail++;
    complete_run();
  end

  initial begin
    logic [3:0]  op;
    logic [31:0] a;
    logic [31:0] b;
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
    wait_idle();
    check_map(1'b1, 1'b1);
    // Operations held back to back, corner cases first
    alu_valid = 1'b1;
    foreach (eop[i]) alu_chk(eop[i], ea[i], eb[i]);
    for (int i = 0; i < 400; i++) begin
      op = 4'(rnd() % 15);
      a = rnd();
      b = rnd();
      if (op == 4'h5) begin
        a = rnd() % 32'h7FFF + 32'h1;
        b = a + rnd() % (32'h8000 - a);
      end
      if (op inside {4'h9, 4'hA}) b = rnd() % 32'h1F - 32'hF;
      if (op inside {4'hB, 4'hC}) b = rnd() % 32'h3F - 32'h1F;
      if (op == 4'h6 && a[15:0] == 16'h8000) a[0] = 1'b1;
      alu_chk(op, a, b);
    end
    alu_valid = 1'b0;
    esmp_valid = 1'b1;
    for (int i = 0; i < 20; i++) begin
      esmp_data = 16'(rnd());
      @(negedge ref_clk);
      check({emsk_valid_q, emsk_data_q}, {1'b1, esmp_data & schfa_pkg::SMP_MASK});
    end
    esmp_valid = 1'b0;
    // Frames: plain, homing from away, homing from home, bad homing, plain, two homing
    for (int f = 0; f < 7; f++) begin
      if (f == 1) dirty();
      far.send_frame(fh[f], fb[f], f % 2 == 0, rnd());
      check({31'h0, home_early_q}, {31'h0, home && fh[f]});
      if (fh[f] && !fb[f]) check({31'h0, par_ready}, 32'h0);
      sub_exp = home && fh[f] && !fb[f];
      far.send_speech(f % 2 == 0, rnd());
      if (fh[f] && !fb[f]) check({31'h0, home_busy}, 32'h1);
      home = fh[f] && !fb[f];
      wait_idle();
      check(32'(exp_spk.size() + exp_par.size()), 32'h0);
      sub_exp = 1'b0;
      if (f == 1) check_map(1'b0, 1'b1);
    end
    dirty();
    enc_home_req = 1'b1;
    @(negedge ref_clk);
    enc_home_req = 1'b0;
    wait_idle();
    check_map(1'b1, 1'b0);
    check(32'(far.n_stall), 32'h0);
    // A reset in mid-run homes both halves, where inband homing clears only the decoder half
    dirty();
    rst_n = 1'b0;
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
    wait_idle();
    check_map(1'b1, 1'b1);
    complete_run();
  end
endmodule
`default_nettype wire
